// [hdl/dpr_device.sv]
// Synchronous dual-port 4K x 9 RAM: registered inputs, self-timed write, async drive enable
`default_nettype none

module dpr_device
   import dpr_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   dpr_port_if.device              port_if [PORTS],
   output logic       [PORTS-1:0]  standby,
   output logic       [PORTS-1:0]  write_busy,
   output logic                    addr_clash
);

   // ------------------------------------------------------------------
   // Shared storage
   // ------------------------------------------------------------------
   // No reset on the array or the address/write-data registers: like the part,
   // their contents are undefined until the host loads them
   logic [DATA_W-1:0] mem [DEPTH];

   // Per-port commit requests gathered for the single array writer
   logic [PORTS-1:0]  cmt_en;
   logic [ADDR_W-1:0] cmt_addr [PORTS];
   logic [DATA_W-1:0] cmt_data [PORTS];

   // ------------------------------------------------------------------
   // Port logic, one copy per port
   // ------------------------------------------------------------------
   for (genvar i = 0; i < PORTS; i++) begin : g_port

      logic [ADDR_W-1:0] addr_ff;
      logic [DATA_W-1:0] write_word_ff;
      logic [DATA_W-1:0] read_word_ff;
      logic              wr_ff;
      logic              rd_ff;
      logic              standby_ff;
      logic [ADDR_W-1:0] nxt_addr;
      logic [DATA_W-1:0] nxt_read_word;
      logic              sample_wr;
      logic              sample_rd;

      // Decode of the control pins as they stand at this edge
      assign sample_wr = (port_if[i].select_n == PIN_ON_N) && (port_if[i].write_n == PIN_ON_N);
      assign sample_rd = (port_if[i].select_n == PIN_ON_N) && (port_if[i].write_n == PIN_OFF_N);

      // ------------------------------------------------------------------
      // Input registers
      // ------------------------------------------------------------------
      // The gate stalls only address and data; control pins are taken
      // every edge so a deselect is never missed
      assign nxt_addr = (port_if[i].clock_gate_n == PIN_ON_N) ? port_if[i].addr : addr_ff;

      always_ff @(posedge sys_clk) begin
         if (port_if[i].clock_gate_n == PIN_ON_N) begin
            addr_ff <= port_if[i].addr;
         end
      end

      // Data comes from the resolved pins, so a write sampled while this
      // port still drives a read word stores that word: the min-cycle
      // read-then-write corruption the host avoids with the drive enable
      always_ff @(posedge sys_clk) begin
         if (port_if[i].clock_gate_n == PIN_ON_N) begin
            write_word_ff <= port_if[i].data_pins;
         end
      end

      // ------------------------------------------------------------------
      // Command registers
      // ------------------------------------------------------------------
      // A write stays open for exactly one cycle: the edge that samples it
      // opens it and the next edge closes it, with no strobe of its own
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            wr_ff <= 1'b0;
         end else begin
            wr_ff <= sample_wr;
         end
      end

      // A read owns the pins only until the next edge; any other command,
      // deselect included, releases them at that edge
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            rd_ff <= 1'b0;
         end else begin
            rd_ff <= sample_rd;
         end
      end

      // Standby is per cycle: one deselected edge powers the port down and
      // the next selected edge wakes it with no extra latency
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            standby_ff <= 1'b1;
         end else begin
            standby_ff <= (port_if[i].select_n == PIN_OFF_N);
         end
      end

      // ------------------------------------------------------------------
      // Write commit
      // ------------------------------------------------------------------
      // The write opened at one edge lands in the array at the next edge,
      // using what the registers held between the two edges
      assign cmt_en[i]   = wr_ff;
      assign cmt_addr[i] = addr_ff;
      assign cmt_data[i] = write_word_ff;

      // ------------------------------------------------------------------
      // Read path
      // ------------------------------------------------------------------
      // Read uses the value the address register is taking at this edge.
      // A commit from this port to the same word is forwarded so that a
      // read right behind a write sees the new data, not the stale cell
      always_comb begin
         nxt_read_word = mem[nxt_addr];
         if (wr_ff && (addr_ff == nxt_addr)) begin
            nxt_read_word = write_word_ff;
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            read_word_ff <= DATA_RST;
         end else if (sample_rd) begin
            read_word_ff <= nxt_read_word;
         end
      end

      // ------------------------------------------------------------------
      // Pin drivers
      // ------------------------------------------------------------------
      // Pins float on deselect, write and disable; the drive enable acts
      // with no clock in between so an async bus can turn the pins around
      assign port_if[i].dev_data = read_word_ff;
      assign port_if[i].dev_oe   = rd_ff && (port_if[i].drive_en_n == PIN_ON_N);

      // ------------------------------------------------------------------
      // Status outputs
      // ------------------------------------------------------------------
      assign standby[i]    = standby_ff;
      assign write_busy[i] = wr_ff;

   end

   // ------------------------------------------------------------------
   // Array writer
   // ------------------------------------------------------------------
   // Both ports reach the array on the same edge; when both write the
   // same word the higher-numbered port lands last and wins.
   // A word written by one port reads back on the other only after this edge
   always_ff @(posedge sys_clk) begin
      for (int p = 0; p < PORTS; p++) begin
         if (cmt_en[p]) begin
            mem[cmt_addr[p]] <= cmt_data[p];
         end
      end
   end

   // ------------------------------------------------------------------
   // Same-word write clash flag
   // ------------------------------------------------------------------
   // Only a report: the array has already taken port 1's word, and the
   // flag is registered at the commit edge itself, so it never gates the write path
   logic addr_clash_ff;
   logic nxt_addr_clash;

   always_comb begin
      nxt_addr_clash = 1'b0;
      for (int p = 1; p < PORTS; p++) begin
         if (cmt_en[0] && cmt_en[p] && (cmt_addr[0] == cmt_addr[p])) begin
            nxt_addr_clash = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         addr_clash_ff <= 1'b0;
      end else begin
         addr_clash_ff <= nxt_addr_clash;
      end
   end

   assign addr_clash = addr_clash_ff;

endmodule

`default_nettype wire

// [hdl/dpr_pkg.sv]
// Shared constants and types for the dual-port RAM port and its host
`default_nettype none

package dpr_pkg;

   // ------------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 9;
   localparam int DEPTH  = 4096;
   localparam int PORTS  = 2;

   // ------------------------------------------------------------------
   // Pin levels and reset values
   // ------------------------------------------------------------------
   localparam logic              PIN_ON_N   = 1'h0;
   localparam logic              PIN_OFF_N  = 1'h1;
   localparam logic [ADDR_W-1:0] ADDR_RST   = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RST   = 9'h000;
   localparam logic [DATA_W-1:0] DATA_FLOAT = 9'h1ff;

   // ------------------------------------------------------------------
   // Host sequencer states, Gray coded along init-idle-cmd-capture
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      HS_INIT = 2'h0,
      HS_IDLE = 2'h1,
      HS_CMD  = 2'h3,
      HS_RCAP = 2'h2
   } dpr_host_state_type;

endpackage

`default_nettype wire

// [hdl/dpr_port_if.sv]
// Pin bundle of one RAM port, joining the device end and the host end
`default_nettype none

interface dpr_port_if;
   import dpr_pkg::*;

   logic              clock_gate_n;
   logic              select_n;
   logic              write_n;
   logic              drive_en_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] host_data;
   logic              host_oe;
   logic [DATA_W-1:0] dev_data;
   logic              dev_oe;
   logic [DATA_W-1:0] data_pins;

   // Resolved bus level; a floating bus reads as all ones (pull-ups).
   // The device wins a fight, which is how a read/write collision corrupts
   assign data_pins = dev_oe ? dev_data : (host_oe ? host_data : DATA_FLOAT);

   modport device (
      input  clock_gate_n,
      input  select_n,
      input  write_n,
      input  drive_en_n,
      input  addr,
      input  data_pins,
      output dev_data,
      output dev_oe
   );

   modport host (
      output clock_gate_n,
      output select_n,
      output write_n,
      output drive_en_n,
      output addr,
      output host_data,
      output host_oe,
      input  data_pins
   );

endinterface

`default_nettype wire

// [hdl/dpr_host.sv]
// Host end of one RAM port: turns single read/write requests into pin cycles
`default_nettype none

module dpr_host
   import dpr_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   dpr_port_if.host                port_if,
   input  wire logic               req_valid,
   input  wire logic               req_write,
   input  wire logic [ADDR_W-1:0]  req_addr,
   input  wire logic [DATA_W-1:0]  req_wdata,
   output logic                    req_ready,
   output logic                    rsp_valid,
   output logic       [DATA_W-1:0] rsp_rdata
);

   dpr_host_state_type state_ff;

   logic              gate_n_ff;
   logic              sel_n_ff;
   logic              wr_n_ff;
   logic              oe_n_ff;
   logic              host_oe_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic              rsp_valid_ff;
   logic [DATA_W-1:0] rsp_rdata_ff;

   assign req_ready = (state_ff == HS_IDLE);

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff <= HS_INIT;
      end else begin
         case (state_ff)
            HS_INIT: state_ff <= HS_IDLE;
            HS_IDLE: if (req_valid) state_ff <= HS_CMD;
            HS_CMD:  state_ff <= (wr_n_ff == PIN_ON_N) ? HS_IDLE : HS_RCAP;
            HS_RCAP: state_ff <= HS_IDLE;
            default: state_ff <= HS_INIT;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------------
   // Gate comes out of reset low so the device input registers load on
   // the first edges; afterwards it is low only in command cycles
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         gate_n_ff  <= PIN_ON_N;
         sel_n_ff   <= PIN_OFF_N;
         wr_n_ff    <= PIN_OFF_N;
         oe_n_ff    <= PIN_OFF_N;
         host_oe_ff <= 1'b0;
         addr_ff    <= ADDR_RST;
         wdata_ff   <= DATA_RST;
      end else begin
         case (state_ff)
            HS_IDLE: begin
               gate_n_ff <= PIN_OFF_N;
               if (req_valid) begin
                  gate_n_ff  <= PIN_ON_N;
                  sel_n_ff   <= PIN_ON_N;
                  wr_n_ff    <= req_write ? PIN_ON_N : PIN_OFF_N;
                  addr_ff    <= req_addr;
                  wdata_ff   <= req_wdata;
                  host_oe_ff <= req_write;
                  // Drive enable is high for every write cycle, so read data
                  // never meets write data and no write needs repeating
                  oe_n_ff    <= req_write ? PIN_OFF_N : PIN_ON_N;
               end
            end
            HS_CMD: begin
               gate_n_ff  <= PIN_OFF_N;
               sel_n_ff   <= PIN_OFF_N;
               wr_n_ff    <= PIN_OFF_N;
               host_oe_ff <= 1'b0;
            end
            HS_RCAP: oe_n_ff <= PIN_OFF_N;
            default: gate_n_ff <= PIN_OFF_N;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Read capture
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= DATA_RST;
      end else begin
         rsp_valid_ff <= (state_ff == HS_RCAP);
         if (state_ff == HS_RCAP) begin
            rsp_rdata_ff <= port_if.data_pins;
         end
      end
   end

   assign rsp_valid = rsp_valid_ff;
   assign rsp_rdata = rsp_rdata_ff;

   assign port_if.clock_gate_n = gate_n_ff;
   assign port_if.select_n     = sel_n_ff;
   assign port_if.write_n      = wr_n_ff;
   assign port_if.drive_en_n   = oe_n_ff;
   assign port_if.addr         = addr_ff;
   assign port_if.host_data    = wdata_ff;
   assign port_if.host_oe      = host_oe_ff;

endmodule

`default_nettype wire

// [testbench/dpr_port_props.sv]
// Pin-level checker for port 0, where the host end meets the device end
`default_nettype none

module dpr_port_props
   import dpr_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              clock_gate_n,
   input wire logic              select_n,
   input wire logic              write_n,
   input wire logic              drive_en_n,
   input wire logic              host_oe,
   input wire logic              dev_oe,
   input wire logic [DATA_W-1:0] data_pins
);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // The read check starts only on a falling select, so a held select does not retrigger it; the device takes reads and writes on the select level
   sequence s_rd_cmd; $fell(select_n) && write_n && !clock_gate_n; endsequence
   sequence s_rd_out; dev_oe && !drive_en_n; endsequence
   sequence s_wr_cmd; !select_n && !write_n; endsequence

   property p_oe_async; drive_en_n |-> !dev_oe; endproperty
   property p_desel; select_n |=> !dev_oe; endproperty
   property p_rd_walk; s_rd_cmd |=> s_rd_out ##1 (drive_en_n && !dev_oe); endproperty
   property p_rd_cause; dev_oe |-> $past(!select_n && write_n); endproperty
   property p_wr_walk; s_wr_cmd |-> (host_oe && drive_en_n && !clock_gate_n) ##1 select_n; endproperty
   property p_wr_quiet; s_wr_cmd |=> !dev_oe; endproperty
   property p_no_fight; !(host_oe && dev_oe); endproperty
   property p_float; (drive_en_n && !host_oe) |-> data_pins == DATA_FLOAT; endproperty
   property p_gate_init; $rose(rst_n) |-> !clock_gate_n; endproperty

   a_oe_async:  assert property (p_oe_async) else $error("pins driven with drive enable high");
   a_desel:     assert property (p_desel) else $error("pins driven after deselect");
   a_rd_walk:   assert property (p_rd_walk) else $error("read word not driven one edge after read");
   a_rd_cause:  assert property (p_rd_cause) else $error("pins driven without a sampled read");
   a_wr_walk:   assert property (p_wr_walk) else $error("write cycle pins wrong");
   a_wr_quiet:  assert property (p_wr_quiet) else $error("device drives after a write");
   a_no_fight:  assert property (p_no_fight) else $error("host and device drive together");
   a_float:     assert property (p_float) else $error("released bus not at float level");
   a_gate_init: assert property (p_gate_init) else $error("clock gate not low at power-up");
endmodule

`default_nettype wire

// [testbench/sync_dual_port_ram_port_tb.sv]
// Self-checking bench: host end on port 0, bench-driven pins on port 1
`default_nettype none

module sync_dual_port_ram_port_tb
   import dpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              sys_clk;
   logic              rst_n;
   logic              req_valid;
   logic              req_write;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata;
   logic              req_ready;
   logic              rsp_valid;
   logic [DATA_W-1:0] rsp_rdata;
   logic [PORTS-1:0]  standby;
   logic [PORTS-1:0]  write_busy;
   logic              addr_clash;
   logic [DATA_W-1:0] model [DEPTH];
   logic [ADDR_W-1:0] used [$];
   logic [ADDR_W-1:0] a;
   logic [ADDR_W-1:0] b;
   logic [DATA_W-1:0] d;
   int                fails;
   int                samples_checked;

   dpr_port_if if_p [PORTS] ();

   dpr_device dpr_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .port_if(if_p), .standby(standby),
                            .write_busy(write_busy), .addr_clash(addr_clash));
   dpr_host dpr_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .port_if(if_p[0]), .req_valid(req_valid),
                        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
                        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   dpr_port_props dpr_port_props_i (.sys_clk(sys_clk), .rst_n(rst_n), .clock_gate_n(if_p[0].clock_gate_n),
                                    .select_n(if_p[0].select_n), .write_n(if_p[0].write_n),
                                    .drive_en_n(if_p[0].drive_en_n), .host_oe(if_p[0].host_oe),
                                    .dev_oe(if_p[0].dev_oe), .data_pins(if_p[0].data_pins));

   // ------------------------------------------------------------------
   // Drivers and comparison
   // ------------------------------------------------------------------
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [DATA_W-1:0] expect_word(input logic [ADDR_W-1:0] ad);
      return model[ad];
   endfunction

   task automatic host_op(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd);
      for (int n = 0; n < 10 && req_ready !== 1'b1; n++) @(negedge sys_clk);
      req_valid = 1'b1;
      req_write = wr;
      req_addr  = ad;
      req_wdata = dd;
      @(negedge sys_clk);
      req_valid = 1'b0;
      chk(9'(req_ready), 9'h000);
      // Let the write commit before the other port may look at it
      repeat (2) @(negedge sys_clk);
      if (wr) model[ad] = dd;
      else begin
         chk(9'(rsp_valid), 9'h001);
         chk(rsp_rdata, expect_word(ad));
      end
   endtask

   // Port 1 pins; a released address or data line shows the inverse pattern
   task automatic p1_pins(input logic g, input logic s, input logic w, input logic o,
                          input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd);
      if_p[1].clock_gate_n = g;
      if_p[1].select_n     = s;
      if_p[1].write_n      = w;
      if_p[1].drive_en_n   = o;
      if_p[1].addr         = ad;
      if_p[1].host_data    = dd;
      if_p[1].host_oe      = !s && !w;
      @(negedge sys_clk);
   endtask

   task automatic p1_wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd);
      p1_pins(1'b0, 1'b0, 1'b0, 1'b1, ad, dd);
      chk(9'(write_busy[1]), 9'h001);
      p1_pins(1'b1, 1'b1, 1'b1, 1'b1, ~ad, ~dd);
      chk(9'(write_busy[1]), 9'h000);
      model[ad] = dd;
   endtask

   task automatic p1_rd(input logic [ADDR_W-1:0] ad);
      p1_pins(1'b0, 1'b0, 1'b1, 1'b0, ad, 9'h0aa);
      chk(if_p[1].data_pins, expect_word(ad));
      p1_pins(1'b1, 1'b1, 1'b1, 1'b1, ~ad, 9'h155);
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Clock, watchdog and tests
   // ------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 12'h000;
      req_wdata = 9'h000;
      fails = 0;
      samples_checked = 0;
      void'($urandom(32769));
      p1_pins(1'b0, 1'b1, 1'b1, 1'b1, 12'h000, 9'h000);
      repeat (7) @(negedge sys_clk);
      rst_n = 1'b1;
      chk(9'(standby), 9'h003);
      chk(9'(write_busy), 9'h000);
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'h123;
         host_op(1'b1, a, 9'h1a5 ^ 9'(i));
         p1_rd(a);
         p1_wr(a, 9'h05a ^ 9'(i));
         host_op(1'b0, a, 9'h000);
      end
      $display("test corners done");
      p1_pins(1'b0, 1'b0, 1'b0, 1'b1, 12'h456, 9'h0c3);
      model[12'h456] = 9'h0c3;
      p1_pins(1'b0, 1'b0, 1'b1, 1'b0, 12'h456, 9'h000);
      chk(if_p[1].data_pins, 9'h0c3);
      p1_pins(1'b1, 1'b0, 1'b1, 1'b0, 12'h123, 9'h000);
      chk(if_p[1].data_pins, 9'h0c3);
      if_p[1].drive_en_n = 1'b1;
      #1;
      chk(if_p[1].data_pins, DATA_FLOAT);
      @(negedge sys_clk);
      p1_pins(1'b0, 1'b1, 1'b1, 1'b0, 12'h456, 9'h000);
      chk(if_p[1].data_pins, DATA_FLOAT);
      chk(9'(standby[1]), 9'h001);
      p1_pins(1'b1, 1'b1, 1'b1, 1'b1, 12'hba9, 9'h155);
      $display("test gate and enable done");
      // Same word written by both ports at one edge: port 1 lands last
      a = 12'h7e1;
      req_valid = 1'b1;
      req_write = 1'b1;
      req_addr  = a;
      req_wdata = 9'h0f0;
      @(negedge sys_clk);
      req_valid = 1'b0;
      p1_pins(1'b0, 1'b0, 1'b0, 1'b1, a, 9'h10f);
      chk(9'(write_busy), 9'h003);
      p1_pins(1'b1, 1'b1, 1'b1, 1'b1, ~a, 9'h0f0);
      chk(9'(addr_clash), 9'h001);
      model[a] = 9'h10f;
      p1_rd(a);
      chk(9'(addr_clash), 9'h000);
      $display("test clash done");
      for (int i = 0; i < 40; i++) begin
         a = ADDR_W'($urandom);
         d = DATA_W'($urandom);
         used.push_back(a);
         if ($urandom % 2) host_op(1'b1, a, d);
         else p1_wr(a, d);
         b = used[$urandom % used.size()];
         if ($urandom % 2) host_op(1'b0, b, 9'h000);
         else p1_rd(b);
      end
      $display("test random done");
      stop_test();
   end
endmodule

`default_nettype wire
